// [logic/three_port_gpio.sv]
/*
  Three 8-bit general purpose ports with register port, open-drain
  option and alternate functions on the first port, and analog input
  sharing with pull-ups on the third port.
  Assumes pins are synchronous to ref_clk_i and that a pad ring turns
  level/oe pairs into real pins and pull-ups.
*/
// Functional notes
// - first port direction bit 0 input, 1 output; resets to zero.
// - first port output latch resets to all ones.
// - drain-select bit 0 push-pull tri-state, 1 sink-only; resets zero.
// - first port latch and read-only pin-level register at separate addresses.
// - first port read-modify-write never copies pins into input-bit latches.
// - first port bits carry serial, uart, interrupt and timer alternates.
// - second port direction and latch reset to zero; 1 means output.
// - second port data read returns pin levels on input bits.
// - third port direction, latch reset 0; pin-disable resets 1.
// - third port mode from direction, latch and analog pin-disable bit.
// - analog input bits of the third port read as 0.
// - fixed-zero input bits read 0 regardless of pin or pull-up.
// - pull-up enabled per bit, never on an output-mode pin.
// - converter channel comes from a separate channel-select field.
`timescale 1ns/1ps

module three_port_gpio
  import gpio_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic [ADDR_W-1:0]      addr_i,
  input  wire logic [PORT_W-1:0]      wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [PORT_W-1:0]      rdata_o,
  input  wire logic [PORT_W-1:0]      first_pin_i,
  output pin_drive_t                  first_drive_o,
  input  wire logic [PORT_W-1:0]      second_pin_i,
  output pin_drive_t                  second_drive_o,
  input  wire logic [PORT_W-1:0]      third_pin_i,
  output pin_drive_t                  third_drive_o,
  output logic      [PORT_W-1:0]      third_pullup_o,
  output logic      [PORT_W-1:0]      analog_enable_o,
  output logic      [CONV_CHAN_W-1:0] analog_channel_select_o,
  output logic                        stop_flag_o,
  input  wire alt_out_t               alt_out_i,
  output alt_in_t                     alt_in_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // output bits return the latch, input bits return the pin
  function automatic logic [PORT_W-1:0] mix_read(
    input logic [PORT_W-1:0] dir,
    input logic [PORT_W-1:0] latch,
    input logic [PORT_W-1:0] pins
  );
    mix_read = (dir & latch) | (~dir & pins);
  endfunction

  // a write strobe aimed at one register offset
  function automatic logic write_hit(
    input logic              wr,
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    write_hit = wr && (addr == ofs);
  endfunction

  // stop mode without output keep releases every driver
  function automatic logic [PORT_W-1:0] gate_oe(
    input logic              float_all,
    input logic [PORT_W-1:0] oe
  );
    gate_oe = float_all ? '0 : oe;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [PORT_W-1:0]      first_port_output_latch;
  logic [PORT_W-1:0]      first_port_direction;
  logic [PORT_W-1:0]      first_port_drain_select;
  logic [PORT_W-1:0]      second_port_output_latch;
  logic [PORT_W-1:0]      second_port_direction;
  logic [PORT_W-1:0]      third_port_output_latch;
  logic [PORT_W-1:0]      third_port_direction;
  logic [PORT_W-1:0]      third_port_pullup_enable;
  logic                   analog_pin_disable;
  logic [CONV_CHAN_W-1:0] analog_channel_select;
  logic                   stop_flag;
  logic                   stop_output_keep;

  logic                   outputs_float;
  logic [PORT_W-1:0]      first_alt_level;
  logic [PORT_W-1:0]      first_level;
  logic [PORT_W-1:0]      third_read;
  logic [PORT_W-1:0]      next_rdata;

  logic                   wr_first_latch;
  logic                   wr_first_dir;
  logic                   wr_first_drain;
  logic                   wr_second_latch;
  logic                   wr_second_dir;
  logic                   wr_third_latch;
  logic                   wr_third_dir;
  logic                   wr_third_pullup;
  logic                   wr_conv_ctrl;
  logic                   wr_sys_ctrl;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_first_latch  = write_hit(wr_i, addr_i, FIRST_LATCH_OFS);
  assign wr_first_dir    = write_hit(wr_i, addr_i, FIRST_DIR_OFS);
  assign wr_first_drain  = write_hit(wr_i, addr_i, FIRST_DRAIN_OFS);
  assign wr_second_latch = write_hit(wr_i, addr_i, SECOND_LATCH_OFS);
  assign wr_second_dir   = write_hit(wr_i, addr_i, SECOND_DIR_OFS);
  assign wr_third_latch  = write_hit(wr_i, addr_i, THIRD_LATCH_OFS);
  assign wr_third_dir    = write_hit(wr_i, addr_i, THIRD_DIR_OFS);
  assign wr_third_pullup = write_hit(wr_i, addr_i, THIRD_PULLUP_OFS);
  assign wr_conv_ctrl    = write_hit(wr_i, addr_i, CONV_CTRL_OFS);
  assign wr_sys_ctrl     = write_hit(wr_i, addr_i, SYS_CTRL_OFS);

  // ----------------------------------------------------------------
  // first port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      first_port_output_latch <= FIRST_LATCH_RST;
      first_port_direction    <= FIRST_DIR_RST;
      first_port_drain_select <= FIRST_DRAIN_RST;
    end
    else
    begin
      // the latch is written whole; pins never reach it through a read
      if (wr_first_latch)
        first_port_output_latch <= wdata_i;
      if (wr_first_dir)
        first_port_direction <= wdata_i;
      if (wr_first_drain)
        first_port_drain_select <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // second port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      second_port_output_latch <= SECOND_LATCH_RST;
      second_port_direction    <= SECOND_DIR_RST;
    end
    else
    begin
      if (wr_second_latch)
        second_port_output_latch <= wdata_i;
      if (wr_second_dir)
        second_port_direction <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // third port and converter control
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      third_port_output_latch  <= THIRD_LATCH_RST;
      third_port_direction     <= THIRD_DIR_RST;
      third_port_pullup_enable <= THIRD_PULLUP_RST;
      analog_pin_disable       <= DISABLE_RST;
      analog_channel_select    <= CHAN_RST;
    end
    else
    begin
      if (wr_third_latch)
        third_port_output_latch <= wdata_i;
      if (wr_third_dir)
        third_port_direction <= wdata_i;
      if (wr_third_pullup)
        third_port_pullup_enable <= wdata_i;
      if (wr_conv_ctrl)
      begin
        analog_pin_disable    <= wdata_i[CONV_DISABLE_BIT];
        analog_channel_select <= wdata_i[CONV_CHAN_LSB +: CONV_CHAN_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // system control: stop mode and output keep
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stop_flag        <= 1'b0;
      stop_output_keep <= 1'b0;
    end
    else if (wr_sys_ctrl)
    begin
      stop_flag        <= wdata_i[SYS_STOP_BIT];
      stop_output_keep <= wdata_i[SYS_KEEP_BIT];
    end
  end

  assign outputs_float = stop_flag & ~stop_output_keep;
  assign stop_flag_o   = stop_flag;

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // alternate outputs are gated by the latch, which software sets to 1
  assign first_alt_level = {1'b1, 1'b1, alt_out_i.uart2_transmit_pin, 1'b1,
                            1'b1, alt_out_i.uart1_transmit_pin, 1'b1,
                            alt_out_i.serial2_clock_pin};
  assign first_level = first_port_output_latch & first_alt_level;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      first_drive_o <= '0;
    else
    begin
      first_drive_o.level <= first_level;
      // open-drain bits only enable the driver while pulling low
      first_drive_o.oe    <= gate_oe(outputs_float,
                                     first_port_direction &
                                     (~first_port_drain_select | ~first_level));
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      second_drive_o <= '0;
    else
    begin
      second_drive_o.level <= second_port_output_latch;
      second_drive_o.oe    <= gate_oe(outputs_float, second_port_direction);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      third_drive_o <= '0;
    else
    begin
      third_drive_o.level <= third_port_output_latch;
      third_drive_o.oe    <= gate_oe(outputs_float, third_port_direction);
    end
  end

  // ----------------------------------------------------------------
  // third port modes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      third_pullup_o  <= '0;
      analog_enable_o <= '0;
    end
    else
    begin
      third_pullup_o  <= third_port_pullup_enable & ~third_port_direction;
      analog_enable_o <= analog_pin_disable ? '0 :
                         ~third_port_direction & ~third_port_output_latch;
    end
  end

  assign analog_channel_select_o = analog_channel_select;

  // input bits with latch 0 read 0 in both fixed-zero and analog modes
  assign third_read = mix_read(third_port_direction, third_port_output_latch,
                               third_pin_i & third_port_output_latch);

  // ----------------------------------------------------------------
  // alternate inputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      alt_in_o <= '0;
    else
    begin
      alt_in_o.serial2_clock_pin       <= first_pin_i[0];
      alt_in_o.uart1_receive_pin       <= first_pin_i[1];
      alt_in_o.uart2_receive_pin       <= first_pin_i[4];
      alt_in_o.ext_interrupt_three_pin <= first_pin_i[6];
      alt_in_o.timer_three_input_pin   <= first_pin_i[6];
      alt_in_o.ext_interrupt_four_pin  <= first_pin_i[7];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = '0;
    unique case (addr_i)
      FIRST_LATCH_OFS:  next_rdata = first_port_output_latch;
      FIRST_PINS_OFS:   next_rdata = first_pin_i;
      FIRST_DIR_OFS:    next_rdata = first_port_direction;
      FIRST_DRAIN_OFS:  next_rdata = first_port_drain_select;
      SECOND_LATCH_OFS: next_rdata = mix_read(second_port_direction,
                                              second_port_output_latch,
                                              second_pin_i);
      SECOND_DIR_OFS:   next_rdata = second_port_direction;
      THIRD_LATCH_OFS:  next_rdata = third_read;
      THIRD_DIR_OFS:    next_rdata = third_port_direction;
      THIRD_PULLUP_OFS: next_rdata = third_port_pullup_enable;
      CONV_CTRL_OFS:
      begin
        next_rdata[CONV_DISABLE_BIT]                  = analog_pin_disable;
        next_rdata[CONV_CHAN_LSB +: CONV_CHAN_W]      = analog_channel_select;
      end
      SYS_CTRL_OFS:
      begin
        next_rdata[SYS_STOP_BIT] = stop_flag;
        next_rdata[SYS_KEEP_BIT] = stop_output_keep;
      end
      default:          next_rdata = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rdata_o <= '0;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= '0;
  end

endmodule // three_port_gpio

// [include/gpio_pkg.sv]
/*
  Shared constants and carrier types for the three-port I/O block.
  Assumes a byte-wide register port with a 12-bit byte address.
*/
package gpio_pkg;

  localparam int PORT_W = 8;
  localparam int ADDR_W = 12;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FIRST_LATCH_OFS  = 12'h004;
  localparam logic [ADDR_W-1:0] SECOND_LATCH_OFS = 12'h005;
  localparam logic [ADDR_W-1:0] THIRD_LATCH_OFS  = 12'h006;
  localparam logic [ADDR_W-1:0] FIRST_PINS_OFS   = 12'h00A;
  localparam logic [ADDR_W-1:0] FIRST_DIR_OFS    = 12'h00C;
  localparam logic [ADDR_W-1:0] SECOND_DIR_OFS   = 12'h00D;
  localparam logic [ADDR_W-1:0] FIRST_DRAIN_OFS  = 12'h02D;
  localparam logic [ADDR_W-1:0] THIRD_DIR_OFS    = 12'h02E;
  localparam logic [ADDR_W-1:0] CONV_CTRL_OFS    = 12'h030;
  localparam logic [ADDR_W-1:0] SYS_CTRL_OFS     = 12'h038;
  localparam logic [ADDR_W-1:0] THIRD_PULLUP_OFS = 12'hFBC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CONV_DISABLE_BIT = 7;
  localparam int CONV_CHAN_LSB    = 0;
  localparam int CONV_CHAN_W      = 4;
  localparam int SYS_STOP_BIT     = 7;
  localparam int SYS_KEEP_BIT     = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0] FIRST_LATCH_RST  = 8'hFF;
  localparam logic [PORT_W-1:0] FIRST_DIR_RST    = 8'h00;
  localparam logic [PORT_W-1:0] FIRST_DRAIN_RST  = 8'h00;
  localparam logic [PORT_W-1:0] SECOND_LATCH_RST = 8'h00;
  localparam logic [PORT_W-1:0] SECOND_DIR_RST   = 8'h00;
  localparam logic [PORT_W-1:0] THIRD_LATCH_RST  = 8'h00;
  localparam logic [PORT_W-1:0] THIRD_DIR_RST    = 8'h00;
  localparam logic [PORT_W-1:0] THIRD_PULLUP_RST = 8'h00;
  localparam logic              DISABLE_RST      = 1'b1;
  localparam logic [CONV_CHAN_W-1:0] CHAN_RST    = 4'h0;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PORT_W-1:0] level;
    logic [PORT_W-1:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic serial2_clock_pin;
    logic uart1_transmit_pin;
    logic uart2_transmit_pin;
  } alt_out_t;

  typedef struct packed {
    logic serial2_clock_pin;
    logic uart1_receive_pin;
    logic uart2_receive_pin;
    logic ext_interrupt_three_pin;
    logic timer_three_input_pin;
    logic ext_interrupt_four_pin;
  } alt_in_t;

endpackage

// [verif/gpio_asserts.sv]
/*
  Port-level checker for the three-port I/O block.
  Assumes it is bound to three_port_gpio and sees only its ports.
*/
`timescale 1ns/1ps

module gpio_asserts
  import gpio_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              sys_rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [PORT_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [PORT_W-1:0] rdata_o,
  input wire logic [PORT_W-1:0] first_pin_i,
  input wire pin_drive_t        first_drive_o,
  input wire logic [PORT_W-1:0] second_pin_i,
  input wire pin_drive_t        second_drive_o,
  input wire pin_drive_t        third_drive_o,
  input wire logic [PORT_W-1:0] third_pullup_o,
  input wire logic [PORT_W-1:0] analog_enable_o,
  input wire logic              stop_flag_o,
  input wire alt_in_t           alt_in_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence dir_wr_s;    wr_i && addr_i == FIRST_DIR_OFS; endsequence
  sequence drain_wr_s;  wr_i && addr_i == FIRST_DRAIN_OFS; endsequence
  sequence sec_dir_s;   wr_i && addr_i == SECOND_DIR_OFS; endsequence

  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  pin_read_a: assert property (rd_i && addr_i == FIRST_PINS_OFS |=>
    rdata_o == $past(first_pin_i)) else $error("pin register read wrong");
  dir_oe_a: assert property (dir_wr_s ##1 !(wr_i && addr_i == FIRST_DIR_OFS) |=>
    (first_drive_o.oe & ~$past(wdata_i, 2)) == 8'h00) else $error("first oe outside direction");
  drain_sink_a: assert property ((drain_wr_s ##0 wdata_i == 8'hFF)
    ##1 !(wr_i && addr_i == FIRST_DRAIN_OFS) |=>
    (first_drive_o.oe & first_drive_o.level) == 8'h00) else $error("open drain drives high");
  second_oe_a: assert property (sec_dir_s ##1 !(wr_i && addr_i == SECOND_DIR_OFS) |=>
    stop_flag_o || $past(stop_flag_o) || second_drive_o.oe == $past(wdata_i, 2))
    else $error("second oe differs from direction");
  second_read_a: assert property (rd_i && addr_i == SECOND_LATCH_OFS && !$past(wr_i)
    && !stop_flag_o && !$past(stop_flag_o) |=> ((rdata_o ^ $past(second_pin_i))
    & ~$past(second_drive_o.oe)) == 8'h00) else $error("second input bits not pin levels");
  analog_zero_a: assert property (rd_i && addr_i == THIRD_LATCH_OFS && !$past(wr_i) |=>
    (rdata_o & $past(analog_enable_o)) == 8'h00) else $error("analog bit reads nonzero");
  pullup_out_a: assert property ((third_pullup_o & third_drive_o.oe) == 8'h00)
    else $error("pull-up on output pin");
  alt_copy_a: assert property (!$past(sys_rst_i) |-> alt_in_o == {$past(first_pin_i[0]),
    $past(first_pin_i[1]), $past(first_pin_i[4]), $past(first_pin_i[6]),
    $past(first_pin_i[6]), $past(first_pin_i[7])}) else $error("alternate inputs wrong");
endmodule // gpio_asserts

// [verif/pin_model.sv]
/*
  Board model: resolves pin levels from the block's drivers, pull-ups
  and external sources. Assumes ext values stand where nothing drives.
*/
`timescale 1ns/1ps

module pin_model
  import gpio_pkg::*;
(
  input  wire pin_drive_t        first_drive_i,
  input  wire pin_drive_t        second_drive_i,
  input  wire pin_drive_t        third_drive_i,
  input  wire logic [PORT_W-1:0] pullup_i,
  input  wire logic [PORT_W-1:0] first_ext_i,
  input  wire logic [PORT_W-1:0] second_ext_i,
  input  wire logic [PORT_W-1:0] third_ext_i,
  output logic      [PORT_W-1:0] first_pin_o,
  output logic      [PORT_W-1:0] second_pin_o,
  output logic      [PORT_W-1:0] third_pin_o
);
  assign first_pin_o  = (first_drive_i.level & first_drive_i.oe)
                      | (first_ext_i & ~first_drive_i.oe);
  assign second_pin_o = (second_drive_i.level & second_drive_i.oe)
                      | (second_ext_i & ~second_drive_i.oe);
  // pulled-up inputs float high
  assign third_pin_o  = (third_drive_i.level & third_drive_i.oe)
                      | ((third_ext_i | pullup_i) & ~third_drive_i.oe);
endmodule // pin_model

// [verif/testbench.sv]
/*
  Self-checking bench for the three-port I/O block.
  Assumes pin_model and gpio_asserts are compiled alongside the design.
*/
`timescale 1ns/1ps

module testbench;
  import gpio_pkg::*;
  logic              ref_clk_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i    = 12'h000;
  logic [PORT_W-1:0] wdata_i   = 8'h00;
  logic              wr_i      = 1'b0;
  logic              rd_i      = 1'b0;
  logic [PORT_W-1:0] rdata_o, first_pin_i, second_pin_i, third_pin_i, third_pullup_o;
  logic [PORT_W-1:0] analog_enable_o;
  logic [PORT_W-1:0] first_ext = 8'hC3, second_ext = 8'hA5, third_ext = 8'hFF;
  logic [CONV_CHAN_W-1:0] analog_channel_select_o;
  logic              stop_flag_o;
  pin_drive_t        first_drive_o, second_drive_o, third_drive_o;
  alt_out_t          alt_out_i = 3'b111;
  alt_in_t           alt_in_o;
  int                errors = 0;
  int                n_checks = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  three_port_gpio i_three_port_gpio (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .first_pin_i(first_pin_i), .first_drive_o(first_drive_o),
    .second_pin_i(second_pin_i), .second_drive_o(second_drive_o),
    .third_pin_i(third_pin_i), .third_drive_o(third_drive_o),
    .third_pullup_o(third_pullup_o), .analog_enable_o(analog_enable_o),
    .analog_channel_select_o(analog_channel_select_o), .stop_flag_o(stop_flag_o),
    .alt_out_i(alt_out_i), .alt_in_o(alt_in_o));

  pin_model i_pin_model (.first_drive_i(first_drive_o), .second_drive_i(second_drive_o),
    .third_drive_i(third_drive_o), .pullup_i(third_pullup_o), .first_ext_i(first_ext),
    .second_ext_i(second_ext), .third_ext_i(third_ext), .first_pin_o(first_pin_i),
    .second_pin_o(second_pin_i), .third_pin_o(third_pin_i));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [PORT_W-1:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1 chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, rdata_o});
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    settle();
    chk("first drive", 16'hFF00, first_drive_o);
    chk("second drive", 16'h0000, second_drive_o);
    chk("analog", 16'h0000, {4'h0, analog_channel_select_o, analog_enable_o});
    rd(FIRST_LATCH_OFS, 8'hFF);
    rd(FIRST_DIR_OFS, 8'h00);
    rd(FIRST_DRAIN_OFS, 8'h00);
    rd(THIRD_DIR_OFS, 8'h00);
    rd(THIRD_PULLUP_OFS, 8'h00);
    rd(THIRD_LATCH_OFS, 8'h00);
    rd(SECOND_LATCH_OFS, 8'hA5);
    rd(CONV_CTRL_OFS, 8'h80);
    rd(12'h123, 8'h00);
    $display("reset test done");
    wr(FIRST_DIR_OFS, 8'h0F);
    wr(FIRST_LATCH_OFS, 8'h5A);
    settle();
    chk("first drive", 16'h5A0F, first_drive_o);
    rd(FIRST_PINS_OFS, 8'hCA);
    rd(FIRST_LATCH_OFS, 8'h5A);
    wr(FIRST_PINS_OFS, 8'h00);
    rd(FIRST_LATCH_OFS, 8'h5A);
    wr(FIRST_DRAIN_OFS, 8'hFF);
    wr(FIRST_LATCH_OFS, 8'hFF);
    alt_out_i <= 3'b000;
    settle();
    chk("first drive", 16'hDA05, first_drive_o);
    chk("alt in", 16'h0017, {10'h000, alt_in_o});
    $display("first port test done");
    wr(SECOND_DIR_OFS, 8'hF0);
    wr(SECOND_LATCH_OFS, 8'h3C);
    settle();
    chk("second drive", 16'h3CF0, second_drive_o);
    rd(SECOND_LATCH_OFS, 8'h35);
    $display("second port test done");
    third_ext <= 8'h00;
    wr(THIRD_PULLUP_OFS, 8'hFF);
    wr(THIRD_DIR_OFS, 8'h0F);
    wr(THIRD_LATCH_OFS, 8'h33);
    settle();
    chk("pullup", 16'h00F0, {8'h00, third_pullup_o});
    chk("third drive", 16'h330F, third_drive_o);
    rd(THIRD_LATCH_OFS, 8'h33);
    wr(CONV_CTRL_OFS, 8'h05);
    settle();
    chk("analog", 16'h05C0, {4'h0, analog_channel_select_o, analog_enable_o});
    rd(THIRD_LATCH_OFS, 8'h33);
    $display("third port test done");
    wr(SYS_CTRL_OFS, 8'h80);
    settle();
    chk("stop oe", 16'h0001, {first_drive_o.oe | second_drive_o.oe | third_drive_o.oe,
                              7'h00, stop_flag_o});
    wr(SYS_CTRL_OFS, 8'h90);
    settle();
    chk("keep oe", 16'h000F, {8'h00, third_drive_o.oe});
    wr(SYS_CTRL_OFS, 8'h00);
    $display("stop test done");
    summarize();
  end
endmodule // testbench

bind three_port_gpio gpio_asserts i_gpio_asserts (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .first_pin_i(first_pin_i), .first_drive_o(first_drive_o),
  .second_pin_i(second_pin_i), .second_drive_o(second_drive_o),
  .third_drive_o(third_drive_o), .third_pullup_o(third_pullup_o),
  .analog_enable_o(analog_enable_o), .stop_flag_o(stop_flag_o), .alt_in_o(alt_in_o));
